//--- src/fprm_defs.svh
`ifndef FPRM_DEFS_SVH
`define FPRM_DEFS_SVH

// Position of the pin-function select bit inside the 24-bit status word.
`define FPRM_PIN_SEL_BIT 23
// Width of the status word that carries the select bit.
`define FPRM_STATUS_W 24
// Reset value of the pin-function select bit: pause function.
`define FPRM_PIN_SEL_RST 1'h0
// Reset value of the quad-enable bit: pin is not a data line.
`define FPRM_QUAD_RST 1'h0
// Stages in each level synchroniser.
`define FPRM_SYNC_STAGES 2

`endif

//--- src/fprm_pkg.sv
package fprm_pkg;

  // Function that the shared pin serves at a given moment.
  typedef enum logic [1:0] {
    FPRM_FN_PAUSE,
    FPRM_FN_RESET,
    FPRM_FN_DATA
  } fprm_pin_fn_t;

endpackage

//--- src/fprm_link_if.sv
`timescale 1ns/10ps
`default_nettype none

// Signals between the link-side sequencer and the system-side control logic.
interface fprm_link_if;
  import fprm_pkg::*;
  logic         pause_active;  // Serial sequence is suspended, link domain.
  logic         reset_req;     // Reset pin asserted, link domain level.
  fprm_pin_fn_t pin_fn;        // Current pin function, system domain level.

  modport link (output pause_active, output reset_req, input pin_fn);
  modport ctrl (input pause_active, input reset_req, output pin_fn);
endinterface

`default_nettype wire

//--- src/fprm_link_seq.sv
`timescale 1ns/10ps
`default_nettype none

// Link-side logic, clocked by the host's serial clock. It freezes the serial
// bit sequencer during a pause and floats the data output.
module fprm_link_seq
  import fprm_pkg::*;
#(
  parameter int BIT_W = 8
) (
  input  wire logic  sck,
  input  wire logic  rst_n,
  input  wire logic  cs_n,
  input  wire logic  pause_n,
  input  wire logic  so_data,
  output logic       so_out,
  output logic       so_oe,
  output logic [BIT_W-1:0] bit_cnt,
  fprm_link_if.link  lnk
);

  // The function arrives as a level from the other domain; two stages first.
  fprm_pin_fn_t fn_s1_r;
  fprm_pin_fn_t fn_s2_r;
  logic [BIT_W-1:0] cnt_r;    // Position in the serial sequence.
  logic [BIT_W-1:0] cnt_nxt;
  logic             pause_w;  // Pause in force this edge.

  // Synchroniser registers only.
  always_ff @(posedge sck or negedge rst_n) begin
    if (!rst_n) begin
      fn_s1_r <= FPRM_FN_PAUSE;
      fn_s2_r <= FPRM_FN_PAUSE;
    end else begin
      fn_s1_r <= lnk.pin_fn;
      fn_s2_r <= fn_s1_r;
    end
  end

  // Pause only counts while the pin has the pause function and we are selected.
  always_comb begin
    pause_w = (fn_s2_r == FPRM_FN_PAUSE) && !pause_n && !cs_n;
  end

  // Sequencer next value: hold during a pause rather than abort, so a resume
  // continues from the same bit.
  always_comb begin
    cnt_nxt = cnt_r;
    if (cs_n) begin
      cnt_nxt = '0;
    end else if (!pause_w) begin
      cnt_nxt = cnt_r + BIT_W'(1);
    end
  end

  // Inputs are sampled on the rising edge of the serial clock.
  always_ff @(posedge sck or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // Output launched from the falling edge; enable drops whenever pause and select
  // are both low while the pin has the pause function, regardless of the clock, hence the combinational gate.
  logic so_q_r;
  always_ff @(negedge sck or negedge rst_n) begin
    if (!rst_n) begin
      so_q_r <= 1'h0;
    end else begin
      so_q_r <= so_data;
    end
  end

  always_comb begin
    so_out = so_q_r;
    so_oe  = !cs_n && !((fn_s2_r == FPRM_FN_PAUSE) && !pause_n);
  end

  assign bit_cnt          = cnt_r;
  assign lnk.pause_active = pause_w;
  assign lnk.reset_req    = (fn_s2_r == FPRM_FN_RESET) && !pause_n;

  chk_pause_holds_count: assert property (@(posedge sck) disable iff (!rst_n)
    pause_w |=> (cnt_r == $past(cnt_r)))
    else $error("Sequence moved during pause.");

  chk_so_floats_pause: assert property (@(posedge sck) disable iff (!rst_n)
    ((fn_s2_r == FPRM_FN_PAUSE) && !pause_n && !cs_n) |-> !so_oe)
    else $error("Data output driven during pause.");

  chk_resume_advance: assert property (@(posedge sck) disable iff (!rst_n)
    (!cs_n && !pause_w && $past(!cs_n)) |=> (cnt_r == $past(cnt_r) + BIT_W'(1)))
    else $error("Sequence did not resume.");

endmodule

`default_nettype wire

//--- src/fprm_pin_mux.sv
`timescale 1ns/10ps
`default_nettype none
`include "fprm_defs.svh"

// Behaviour
// - Pin is pause or reset, default pause.
// - Quad enable makes pin data line three.
// - Quad off: select 0 pause, 1 reset.
// - Low pause freezes sequence, nothing aborted.
// - Pause and select low float output.
// - Pause high resumes where it stopped.
// - Sample rising edge, drive from falling.
// - Quad mode: four pins become data lines.

// Shared pause/reset/data-line-three pin mux and serial pause handling.
module fprm_pin_mux
  import fprm_pkg::*;
#(
  parameter int BIT_W = 8
) (
  input  wire logic                      sys_clk,
  input  wire logic                      rst_n,
  input  wire logic                      sck,
  input  wire logic                      cs_n,
  input  wire logic                      quad_enable_bit,
  input  wire logic [`FPRM_STATUS_W-1:0] status_word,
  input  wire logic [3:0]                io_in,
  input  wire logic [3:0]                core_io_out,
  input  wire logic [3:0]                core_io_oe,
  input  wire logic                      core_so_data,
  output logic [3:0]                     io_out,
  output logic [3:0]                     io_oe,
  output logic [3:0]                     core_io_in,
  output logic                           pin_function_select_bit,
  output logic                           pause_seen,
  output logic                           hw_reset_req,
  output logic [BIT_W-1:0]               seq_bit_cnt
);

  fprm_link_if lnk ();

  fprm_pin_fn_t fn_r;                 // Registered pin function.
  fprm_pin_fn_t fn_nxt;
  logic         sel_r;                // Select bit, registered.
  logic         pause_s1_r;           // First stage, read only by stage two.
  logic         pause_s2_r;
  logic         rst_s1_r;
  logic         rst_s2_r;
  logic         pause_seen_nxt;
  logic         hw_reset_nxt;
  logic         so_out_w;
  logic         so_oe_w;
  logic [BIT_W-1:0] cnt_w;

  // Function decode: quad enable wins, else the select bit picks pause or reset.
  always_comb begin
    if (quad_enable_bit) begin
      fn_nxt = FPRM_FN_DATA;
    end else if (status_word[`FPRM_PIN_SEL_BIT]) begin
      fn_nxt = FPRM_FN_RESET;
    end else begin
      fn_nxt = FPRM_FN_PAUSE;
    end
  end

  // Status levels are synchronous to the core, so they register without
  // synchronisers; the link flags cross in with two stages each.
  always_comb begin
    pause_seen_nxt = pause_s2_r;
    hw_reset_nxt   = rst_s2_r;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fn_r         <= FPRM_FN_PAUSE;
      sel_r        <= `FPRM_PIN_SEL_RST;
      pause_s1_r   <= 1'h0;
      pause_s2_r   <= 1'h0;
      rst_s1_r     <= 1'h0;
      rst_s2_r     <= 1'h0;
      pause_seen   <= 1'h0;
      hw_reset_req <= 1'h0;
    end else begin
      fn_r         <= fn_nxt;
      sel_r        <= status_word[`FPRM_PIN_SEL_BIT];
      pause_s1_r   <= lnk.pause_active;
      pause_s2_r   <= pause_s1_r;
      rst_s1_r     <= lnk.reset_req;
      rst_s2_r     <= rst_s1_r;
      pause_seen   <= pause_seen_nxt;
      hw_reset_req <= hw_reset_nxt;
    end
  end

  assign lnk.pin_fn              = fn_r;
  assign pin_function_select_bit = sel_r;

  // The serial clock from the host is this instance's only timing reference.
  fprm_link_seq #(
    .BIT_W (BIT_W)
  ) u_seq (
    .sck     (sck),
    .rst_n   (rst_n),
    .cs_n    (cs_n),
    .pause_n (io_in[3]),
    .so_data (core_so_data),
    .so_out  (so_out_w),
    .so_oe   (so_oe_w),
    .bit_cnt (cnt_w),
    .lnk     (lnk)
  );

  // Pin routing. Line 1 is the serial output outside quad mode and obeys the
  // pause float; line 3 only drives when it is a data line. Pin drive is
  // combinational by nature, so these are not registered.
  always_comb begin
    io_out     = core_io_out;
    io_oe      = core_io_oe;
    core_io_in = io_in;
    if (fn_r == FPRM_FN_DATA) begin
      io_oe = core_io_oe;
    end else begin
      io_out[1]     = so_out_w;
      io_oe[1]      = so_oe_w && core_io_oe[1];
      io_oe[3]      = 1'h0;
      core_io_in[3] = 1'h1;
    end
  end

  assign seq_bit_cnt = cnt_w;

  chk_quad_data_fn: assert property (@(posedge sys_clk) disable iff (!rst_n)
    quad_enable_bit |=> (fn_r == FPRM_FN_DATA))
    else $error("Quad enable did not select data line.");

  chk_select_reset: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!quad_enable_bit && status_word[`FPRM_PIN_SEL_BIT]) |=> (fn_r == FPRM_FN_RESET))
    else $error("Select bit did not pick reset.");

  chk_select_pause: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!quad_enable_bit && !status_word[`FPRM_PIN_SEL_BIT]) |=> (fn_r == FPRM_FN_PAUSE))
    else $error("Default function is not pause.");

  chk_no_drive_pin3: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (fn_r != FPRM_FN_DATA) |-> !io_oe[3])
    else $error("Pin three driven outside quad mode.");

  chk_pause_crosses: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(pause_s2_r) |=> pause_seen)
    else $error("Pause flag did not cross.");

endmodule

`default_nettype wire

//--- verification/fprm_host_model.sv
`timescale 1ns/10ps
`default_nettype none

// Behavioural serial host; it clocks the flash whenever pulse is called, selected or not.
module fprm_host_model (
  output logic       sck,
  output logic       cs_n,
  output logic [3:0] io_in
);
  // Idle: mode 0 clock low, deselected, pause pin high.
  initial begin
    sck = 1'h0;
    cs_n = 1'h1;
    io_in = 4'hD;
  end

  // Pulses of 15 ns; the clock stands still between calls.
  task automatic pulse(input int n);
    repeat (n) begin
      #7.5 sck = 1'h1;
      #7.5 sck = 1'h0;
    end
  endtask

  // Levels move while the clock is low, so they are settled at the next rise.
  task automatic set_pause(input logic lvl);
    #3 io_in[3] = lvl;
  endtask

  // Chip select is held across a whole frame.
  task automatic select(input logic on);
    #3 cs_n = !on;
  endtask
endmodule

`default_nettype wire

//--- verification/test_flash_pause_reset_pin_mux.sv
`timescale 1ns/10ps
`default_nettype none
`include "fprm_defs.svh"

// Bench for the shared pause, reset and data-line-three pin.
module test_flash_pause_reset_pin_mux;
  import fprm_pkg::*;
  logic                      sys_clk, rst_n, sck, cs_n, quad_enable_bit, core_so_data;
  logic [`FPRM_STATUS_W-1:0] status_word;
  logic [3:0]                io_in, core_io_out, core_io_oe, io_out, io_oe, core_io_in;
  logic                      pin_function_select_bit, pause_seen, hw_reset_req;
  logic [7:0]                seq_bit_cnt, c0;
  int                        n_fail, samples_checked;

  fprm_host_model fprm_host_model_inst (.sck(sck), .cs_n(cs_n), .io_in(io_in));
  fprm_pin_mux #(.BIT_W(8)) fprm_pin_mux_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .sck(sck), .cs_n(cs_n),
    .quad_enable_bit(quad_enable_bit), .status_word(status_word), .io_in(io_in),
    .core_io_out(core_io_out), .core_io_oe(core_io_oe), .core_so_data(core_so_data),
    .io_out(io_out), .io_oe(io_oe), .core_io_in(core_io_in),
    .pin_function_select_bit(pin_function_select_bit), .pause_seen(pause_seen),
    .hw_reset_req(hw_reset_req), .seq_bit_cnt(seq_bit_cnt));

  // System clock of 20 ns.
  initial begin
    sys_clk = 1'h0;
    forever #10 sys_clk = ~sys_clk;
  end

  // Waits n cycles and ends at a falling edge, where outputs have settled.
  task automatic wcyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // Compares one value; a mismatch is reported and counted.
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic close_out();
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // After reset the pin is the pause input and nothing is asserted.
  task automatic t_reset();
    chk("select", 8'h00, pin_function_select_bit);
    chk("pause_seen", 8'h00, pause_seen);
    chk("reset_req", 8'h00, hw_reset_req);
  endtask

  // A pause in mid-frame freezes the position and floats the output.
  task automatic t_pause();
    fprm_host_model_inst.select(1'h1);
    fprm_host_model_inst.pulse(3);
    wcyc(1);
    c0 = seq_bit_cnt;
    chk("so_oe before", 8'h01, io_oe[1]);
    fprm_host_model_inst.set_pause(1'h0);
    wcyc(1);
    chk("so_oe paused", 8'h00, io_oe[1]);
    fprm_host_model_inst.pulse(4);
    wcyc(4);
    chk("count held", c0, seq_bit_cnt);
    chk("pause_seen", 8'h01, pause_seen);
    fprm_host_model_inst.set_pause(1'h1);
    fprm_host_model_inst.pulse(2);
    wcyc(5);
    chk("count resumed", c0 + 8'h02, seq_bit_cnt);
    chk("pause_seen off", 8'h00, pause_seen);
    fprm_host_model_inst.select(1'h0);
  endtask

  // Select bit 1 turns the pin into the reset input; no pause follows.
  task automatic t_reset_fn();
    @(posedge sys_clk) status_word <= 24'h800000;
    wcyc(3);
    chk("select", 8'h01, pin_function_select_bit);
    fprm_host_model_inst.select(1'h1);
    fprm_host_model_inst.set_pause(1'h0);
    fprm_host_model_inst.pulse(4);
    wcyc(5);
    chk("reset_req", 8'h01, hw_reset_req);
    chk("pause_seen", 8'h00, pause_seen);
    chk("so_oe", 8'h01, io_oe[1]);
    fprm_host_model_inst.set_pause(1'h1);
    fprm_host_model_inst.pulse(4);
    fprm_host_model_inst.select(1'h0);
    @(posedge sys_clk) status_word <= 24'h000000;
    wcyc(5);
    chk("reset_req off", 8'h00, hw_reset_req);
  endtask

  // Outside quad mode line 1 carries the serial bit launched on the falling
  // edge, the other lines follow the core, and the unused status bits are ignored.
  task automatic t_data_path();
    @(posedge sys_clk) begin
      status_word <= 24'h7FFFFF;
      core_so_data <= 1'h0;
      core_io_out <= 4'h5;
    end
    wcyc(2);
    chk("select low bits", 8'h00, pin_function_select_bit);
    fprm_host_model_inst.select(1'h1);
    fprm_host_model_inst.pulse(1);
    wcyc(1);
    chk("io_out so 0", 8'h05, io_out);
    chk("line3 in idle", 8'h01, core_io_in[3]);
    @(posedge sys_clk) core_so_data <= 1'h1;
    wcyc(1);
    fprm_host_model_inst.pulse(1);
    wcyc(1);
    chk("io_out so 1", 8'h07, io_out);
    fprm_host_model_inst.select(1'h0);
    @(posedge sys_clk) begin
      status_word <= 24'h000000;
      core_io_out <= 4'h0;
    end
    wcyc(2);
  endtask

  // Quad enable makes all four pins data lines; pause and reset are gone.
  task automatic t_quad();
    @(posedge sys_clk) begin
      quad_enable_bit <= 1'h1;
      core_io_oe <= 4'hF;
      core_io_out <= 4'hA;
    end
    fprm_host_model_inst.select(1'h1);
    fprm_host_model_inst.set_pause(1'h0);
    fprm_host_model_inst.pulse(4);
    wcyc(5);
    chk("io_oe", 8'h0F, io_oe);
    chk("io_out", 8'h0A, io_out);
    chk("line3 in", 8'h00, core_io_in[3]);
    chk("pause_seen", 8'h00, pause_seen);
    chk("reset_req", 8'h00, hw_reset_req);
    fprm_host_model_inst.set_pause(1'h1);
    fprm_host_model_inst.select(1'h0);
  endtask

  // Main sequence: inputs at time zero, reset for 12 cycles, then scenarios.
  initial begin
    n_fail = 0;
    samples_checked = 0;
    rst_n = 1'h0;
    quad_enable_bit = 1'h0;
    status_word = 24'h000000;
    core_io_out = 4'h0;
    core_io_oe = 4'h2;
    core_so_data = 1'h1;
    fprm_host_model_inst.pulse(2);
    wcyc(10);
    @(posedge sys_clk) rst_n <= 1'h1;
    wcyc(2);
    t_reset();
    t_pause();
    t_reset_fn();
    t_data_path();
    t_quad();
    close_out();
  end

  // Watchdog well beyond the fewer than one hundred cycles the scenarios need.
  initial begin
    #200000;
    n_fail++;
    close_out();
  end
endmodule

`default_nettype wire
